// *** rtl/mims_irq.sv ***
// interrupt enable and status registers with their event sources
`timescale 1ns/1ps
module mims_irq (
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  input wire logic soft_reset,
  input wire logic reg_select,
  input wire logic reg_write,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rdata_valid,
  input wire logic latched_retry_mode,
  input wire logic bus_master,
  input wire logic bus_retry_input,
  input wire logic tx_end,
  input wire logic collision_pulse,
  input wire logic table_load_complete,
  input wire logic tx_config_read,
  input wire logic tx_config_irq_bit,
  input wire logic rx_sequence_written,
  input wire logic tx_status_written,
  input wire logic list_end_flag,
  input wire logic halt_transmit_cmd,
  input wire logic length_mismatch,
  input wire logic too_many_collisions,
  input wire logic tx_fifo_underrun,
  input wire logic excessive_deferral,
  input wire logic timer_step,
  input wire logic timer_is_zero,
  input wire logic [2:0] tally_step,
  input wire logic [2:0] tally_all_ones,
  input wire logic rx_desc_exhausted,
  input wire logic rx_buffers_exhausted,
  input wire logic rx_area_overrun,
  input wire logic rx_fifo_overflow,
  output logic irq,
  output logic dma_stall,
  output logic [15:0] irq_enable_reg,
  output logic [15:0] irq_status_reg
);

  // register port decode
  wire enable_hit = reg_select && (reg_addr == mims_pkg::IRQ_ENABLE_OFFSET);
  wire status_hit = reg_select && (reg_addr == mims_pkg::IRQ_STATUS_OFFSET);
  wire enable_write = enable_hit && reg_write;
  wire status_write = status_hit && reg_write;
  wire reg_read = reg_select && !reg_write;
  wire [15:0] clear_bits;
  assign clear_bits = status_write ?
    (reg_wdata & mims_pkg::IRQ_WRITABLE_MASK) : 16'h0000;

  // heartbeat watch after each transmission
  mims_pkg::mims_hb_state_type hb_state;
  mims_pkg::mims_hb_state_type next_hb_state;
  logic [9:0] hb_count;
  logic [9:0] next_hb_count;

  always_comb begin
    next_hb_state = hb_state;
    next_hb_count = hb_count;
    unique case (hb_state)
      mims_pkg::HB_IDLE: begin
        next_hb_count = 10'h000;
        if (tx_end) begin
          next_hb_state = mims_pkg::HB_WAIT;
        end
      end
      mims_pkg::HB_WAIT: begin
        if (collision_pulse) begin
          next_hb_state = mims_pkg::HB_IDLE;
        end else if (hb_count == mims_pkg::HEARTBEAT_LAST_COUNT) begin
          next_hb_state = mims_pkg::HB_MISS;
        end else begin
          next_hb_count = hb_count + 10'h001;
        end
      end
      mims_pkg::HB_MISS: begin
        next_hb_state = mims_pkg::HB_IDLE;
      end
      default: begin
        next_hb_state = mims_pkg::HB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hb_state <= mims_pkg::HB_IDLE;
      hb_count <= 10'h000;
    end else if (ce) begin
      hb_state <= next_hb_state;
      hb_count <= next_hb_count;
    end
  end

  // event sources
  wire tx_abort = length_mismatch || too_many_collisions ||
    tx_fifo_underrun || excessive_deferral;
  wire retry_event = bus_retry_input &&
    (!latched_retry_mode || bus_master);
  wire [15:0] set_bits;
  assign set_bits[15] = 1'b0;
  assign set_bits[mims_pkg::BUS_RETRY_BIT] = retry_event;
  assign set_bits[mims_pkg::HEARTBEAT_BIT] =
    (hb_state == mims_pkg::HB_MISS);
  assign set_bits[mims_pkg::TABLE_LOAD_BIT] = table_load_complete;
  assign set_bits[mims_pkg::DESCRIPTOR_IRQ_BIT] =
    tx_config_read && tx_config_irq_bit;
  assign set_bits[mims_pkg::FRAME_RECEIVED_BIT] =
    rx_sequence_written;
  assign set_bits[mims_pkg::TX_COMPLETE_BIT] = tx_status_written &&
    (list_end_flag || halt_transmit_cmd || tx_abort);
  assign set_bits[mims_pkg::TX_FAULT_BIT] =
    tx_status_written && tx_abort;
  assign set_bits[mims_pkg::TIMER_WRAP_BIT] =
    timer_step && timer_is_zero;
  assign set_bits[mims_pkg::RX_DESC_EXHAUSTED_BIT] =
    rx_desc_exhausted;
  assign set_bits[mims_pkg::RX_BUFFERS_EXHAUSTED_BIT] =
    rx_buffers_exhausted;
  assign set_bits[mims_pkg::RX_AREA_OVERRUN_BIT] = rx_area_overrun;
  assign set_bits[mims_pkg::CHECK_TALLY_BIT:mims_pkg::MISSED_TALLY_BIT] =
    tally_step & tally_all_ones;
  assign set_bits[mims_pkg::RX_FIFO_OVERFLOW_BIT] =
    rx_fifo_overflow;

  // per-bit status update, set wins over clear
  logic [15:0] next_status;
  genvar b;
  generate
    for (b = 0; b < 16; b = b + 1) begin : g_status
      assign next_status[b] = set_bits[b] ||
        (irq_status_reg[b] && !clear_bits[b]);
    end
  endgenerate

  wire [15:0] next_enable = enable_write ?
    (reg_wdata & mims_pkg::IRQ_WRITABLE_MASK) : irq_enable_reg;
  wire next_irq = |(next_status & next_enable);
  wire next_stall = latched_retry_mode &&
    next_status[mims_pkg::BUS_RETRY_BIT];
  wire [15:0] read_mux = enable_hit ? irq_enable_reg :
    (status_hit ? irq_status_reg : 16'h0000);

  // soft_reset deliberately touches nothing here
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_enable_reg <= mims_pkg::IRQ_ENABLE_RESET;
      irq_status_reg <= mims_pkg::IRQ_STATUS_RESET;
      irq <= 1'b0;
      dma_stall <= 1'b0;
    end else if (ce) begin
      irq_enable_reg <= next_enable;
      irq_status_reg <= next_status;
      irq <= next_irq;
      dma_stall <= next_stall;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
      reg_rdata_valid <= 1'b0;
    end else if (ce) begin
      reg_rdata <= reg_read ? read_mux : 16'h0000;
      reg_rdata_valid <= reg_read;
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_enable_write;
    ce && enable_write;
  endsequence

  sequence s_status_write;
    ce && status_write;
  endsequence

  sequence s_event;
    ce && (set_bits != 16'h0000);
  endsequence

  property p_enable_store;
    s_enable_write |=> irq_enable_reg ==
      ($past(reg_wdata) & mims_pkg::IRQ_WRITABLE_MASK);
  endproperty
  a_enable_store: assert property (p_enable_store)
    else $error("enable register did not take the written value");

  property p_irq_level;
    irq == |(irq_status_reg & irq_enable_reg);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt pin does not match enabled status");

  property p_write_one_clears;
    s_status_write |=> (irq_status_reg &
      $past(reg_wdata & ~set_bits)) == 16'h0000;
  endproperty
  a_write_one_clears: assert property (p_write_one_clears)
    else $error("status bit written with one stayed set");

  property p_write_zero_keeps;
    s_status_write |=> (irq_status_reg &
      $past(irq_status_reg & ~reg_wdata)) ==
      $past(irq_status_reg & ~reg_wdata);
  endproperty
  a_write_zero_keeps: assert property (p_write_zero_keeps)
    else $error("status bit written with zero was lost");

  property p_set_wins;
    s_event |=> (irq_status_reg & $past(set_bits)) == $past(set_bits);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("status event was lost");

  property p_reserved_zero;
    !irq_enable_reg[15] && !irq_status_reg[15] && !read_mux[15];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit fifteen is not zero");

  property p_latched_stall;
    ce && latched_retry_mode |=>
      dma_stall == irq_status_reg[mims_pkg::BUS_RETRY_BIT];
  endproperty
  a_latched_stall: assert property (p_latched_stall)
    else $error("stall does not follow the retry flag");

  property p_retry_needs_master;
    ce && latched_retry_mode && !bus_master &&
      !irq_status_reg[mims_pkg::BUS_RETRY_BIT] |=>
      !irq_status_reg[mims_pkg::BUS_RETRY_BIT];
  endproperty
  a_retry_needs_master: assert property (p_retry_needs_master)
    else $error("retry flag set while not bus master");

  property p_unlatched_no_stall;
    ce && !latched_retry_mode |=> !dma_stall;
  endproperty
  a_unlatched_no_stall: assert property (p_unlatched_no_stall)
    else $error("stall raised in unlatched mode");

  property p_heartbeat_window;
    hb_state == mims_pkg::HB_MISS |->
      $past(hb_count) == mims_pkg::HEARTBEAT_LAST_COUNT ##1
      irq_status_reg[mims_pkg::HEARTBEAT_BIT] || !$past(ce);
  endproperty
  a_heartbeat_window: assert property (p_heartbeat_window)
    else $error("heartbeat flag timing wrong");

  property p_frame_received;
    ce && rx_sequence_written |=>
      irq_status_reg[mims_pkg::FRAME_RECEIVED_BIT];
  endproperty
  a_frame_received: assert property (p_frame_received)
    else $error("frame received flag not set");

  property p_tx_fault;
    ce && tx_status_written && tx_abort |=>
      irq_status_reg[mims_pkg::TX_FAULT_BIT] &&
      irq_status_reg[mims_pkg::TX_COMPLETE_BIT];
  endproperty
  a_tx_fault: assert property (p_tx_fault)
    else $error("abort did not set done and error flags");

  property p_soft_reset_keeps;
    ce && soft_reset && !status_write |=>
      (irq_status_reg & $past(irq_status_reg)) == $past(irq_status_reg);
  endproperty
  a_soft_reset_keeps: assert property (p_soft_reset_keeps)
    else $error("software reset disturbed status");

  property p_frozen;
    !ce |=> $stable(irq_status_reg) && $stable(irq_enable_reg) &&
      $stable(irq);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("state moved while clock enable low");

  property p_reset_clears;
    disable iff (1'b0) $fell(reset) |->
      irq_enable_reg == mims_pkg::IRQ_ENABLE_RESET &&
      irq_status_reg == mims_pkg::IRQ_STATUS_RESET && !irq;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("registers not cleared by hardware reset");

  property p_table_load;
    ce && table_load_complete |=>
      irq_status_reg[mims_pkg::TABLE_LOAD_BIT];
  endproperty
  a_table_load: assert property (p_table_load)
    else $error("table load done flag not set");

  property p_descriptor_irq;
    ce && tx_config_read && tx_config_irq_bit |=>
      irq_status_reg[mims_pkg::DESCRIPTOR_IRQ_BIT];
  endproperty
  a_descriptor_irq: assert property (p_descriptor_irq)
    else $error("descriptor request flag not set");

  property p_timer_wrap;
    ce && timer_step && timer_is_zero |=>
      irq_status_reg[mims_pkg::TIMER_WRAP_BIT];
  endproperty
  a_timer_wrap: assert property (p_timer_wrap)
    else $error("timer wrap flag not set");

  property p_check_tally;
    ce && tally_step[2] && tally_all_ones[2] |=>
      irq_status_reg[mims_pkg::CHECK_TALLY_BIT];
  endproperty
  a_check_tally: assert property (p_check_tally)
    else $error("check tally wrap flag not set");

  property p_desc_exhausted;
    ce && rx_desc_exhausted |=>
      irq_status_reg[mims_pkg::RX_DESC_EXHAUSTED_BIT];
  endproperty
  a_desc_exhausted: assert property (p_desc_exhausted)
    else $error("descriptor exhausted flag not set");

  property p_buffers_exhausted;
    ce && rx_buffers_exhausted |=>
      irq_status_reg[mims_pkg::RX_BUFFERS_EXHAUSTED_BIT];
  endproperty
  a_buffers_exhausted: assert property (p_buffers_exhausted)
    else $error("resource exhausted flag not set");

  property p_area_overrun;
    ce && rx_area_overrun |=>
      irq_status_reg[mims_pkg::RX_AREA_OVERRUN_BIT];
  endproperty
  a_area_overrun: assert property (p_area_overrun)
    else $error("buffer area overrun flag not set");

  property p_fifo_overflow;
    ce && rx_fifo_overflow |=>
      irq_status_reg[mims_pkg::RX_FIFO_OVERFLOW_BIT];
  endproperty
  a_fifo_overflow: assert property (p_fifo_overflow)
    else $error("receive fifo overrun flag not set");

  property p_frame_irq;
    ce && rx_sequence_written &&
      irq_enable_reg[mims_pkg::FRAME_RECEIVED_BIT] && !enable_write
      |=> irq;
  endproperty
  a_frame_irq: assert property (p_frame_irq)
    else $error("enabled frame received did not raise interrupt");

endmodule // mims_irq

// *** rtl/mims_pkg.sv ***
// constants for the interrupt enable and status block
// Operation
// - each enable bit gates its status bit; 1 passes, 0 blocks
// - hardware reset clears every enable bit
// - enable and status bits 14..0 match one-for-one in the listed order
// - interrupt pin active while any status bit and its enable are set
// - writing 1 clears a status bit; writing 0 leaves it
// - hardware reset clears status; software reset leaves it untouched
// - latched mode: retry flag sets only as bus master; DMA stalls until cleared
// - unlatched mode: DMA resumes without waiting; host still clears the flag
// - heartbeat flag sets when no collision pulse in first 6.4 us after transmit
// - table load done flag sets once the load writes every programmed entry
// - descriptor flag sets when a read config word has its request bit
// - frame received flag sets only after the sequence word is written
// - transmit done sets after status write on list end, halt or abort
// - transmit error flag and enable bit 8 cover faulty transmissions
// - timer flag sets when the 32-bit timer wraps zero to all ones
// - tally flags 3, 2, 1 set when their 16-bit counters wrap to zero
// - bit 6 flags all receive descriptors consumed
// - bit 5 flags all receive resource descriptors consumed
// - bit 4 flags storing data past the receive buffer area end
// - bit 0 flags a receive FIFO overrun
// - enable bit 10 allows interrupts for frames accepted to memory
package mims_pkg;
  localparam logic [5:0] IRQ_ENABLE_OFFSET = 6'h04;
  localparam logic [5:0] IRQ_STATUS_OFFSET = 6'h05;
  localparam logic [15:0] IRQ_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] IRQ_STATUS_RESET = 16'h0000;
  localparam logic [15:0] IRQ_WRITABLE_MASK = 16'h7FFF;
  localparam int BUS_RETRY_BIT = 14;
  localparam int HEARTBEAT_BIT = 13;
  localparam int TABLE_LOAD_BIT = 12;
  localparam int DESCRIPTOR_IRQ_BIT = 11;
  localparam int FRAME_RECEIVED_BIT = 10;
  localparam int TX_COMPLETE_BIT = 9;
  localparam int TX_FAULT_BIT = 8;
  localparam int TIMER_WRAP_BIT = 7;
  localparam int RX_DESC_EXHAUSTED_BIT = 6;
  localparam int RX_BUFFERS_EXHAUSTED_BIT = 5;
  localparam int RX_AREA_OVERRUN_BIT = 4;
  localparam int CHECK_TALLY_BIT = 3;
  localparam int FRAMING_TALLY_BIT = 2;
  localparam int MISSED_TALLY_BIT = 1;
  localparam int RX_FIFO_OVERFLOW_BIT = 0;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int HEARTBEAT_WINDOW_NS = 6400;
  localparam int HEARTBEAT_WINDOW_CYCLES =
    HEARTBEAT_WINDOW_NS / CLOCK_PERIOD_NS;
  localparam logic [9:0] HEARTBEAT_LAST_COUNT =
    10'(HEARTBEAT_WINDOW_CYCLES - 1);
  typedef enum logic [1:0] {
    HB_IDLE = 2'b00,
    HB_WAIT = 2'b01,
    HB_MISS = 2'b11
  } mims_hb_state_type;
endpackage

// *** verif/mims_host.sv ***
// host model that drives the register port
`timescale 1ns/1ps
module mims_host (
  input wire logic clock,
  output logic reg_select,
  output logic reg_write,
  output logic [5:0] reg_addr,
  output logic [15:0] reg_wdata
);
  initial begin
    reg_select = 1'b0;
    reg_write = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 16'h0000;
  end
  // one access per call; released lines show the inverse of the last value
  task automatic access(input logic w, input logic [5:0] a,
                        input logic [15:0] d);
    @(posedge clock);
    #1;
    reg_select = 1'b1;
    reg_write = w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_select = 1'b0;
    reg_write = ~w;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule // mims_host

// *** verif/tb.sv ***
// self-checking bench for the interrupt enable and status block
`timescale 1ns/1ps
module tb;
  logic clock, reset, soft_reset, latched_retry_mode, bus_master;
  logic bus_retry_input, tx_end, collision_pulse, table_load_complete;
  logic tx_config_read, tx_config_irq_bit, rx_sequence_written;
  logic tx_status_written, timer_step, timer_is_zero;
  logic rx_desc_exhausted, rx_buffers_exhausted, rx_area_overrun;
  logic rx_fifo_overflow, reg_select, reg_write, irq, dma_stall;
  logic reg_rdata_valid, ce;
  wire list_end_flag, halt_transmit_cmd, length_mismatch;
  wire too_many_collisions, tx_fifo_underrun, excessive_deferral;
  logic [2:0] tally_step, tally_all_ones;
  logic [5:0] reg_addr, qual;
  logic [15:0] reg_wdata, reg_rdata, irq_enable_reg, irq_status_reg;
  logic [15:0] expq[$];
  logic [15:0] en, e;
  int err_total, comparisons, seed;
  assign {list_end_flag, halt_transmit_cmd, length_mismatch,
    too_many_collisions, tx_fifo_underrun, excessive_deferral} = qual;
  mims_irq dut (.clock, .reset, .ce, .soft_reset, .reg_select,
    .reg_write, .reg_addr, .reg_wdata, .reg_rdata, .reg_rdata_valid,
    .latched_retry_mode, .bus_master, .bus_retry_input, .tx_end,
    .collision_pulse, .table_load_complete, .tx_config_read,
    .tx_config_irq_bit, .rx_sequence_written, .tx_status_written,
    .list_end_flag, .halt_transmit_cmd, .length_mismatch,
    .too_many_collisions, .tx_fifo_underrun, .excessive_deferral,
    .timer_step, .timer_is_zero, .tally_step, .tally_all_ones,
    .rx_desc_exhausted, .rx_buffers_exhausted, .rx_area_overrun,
    .rx_fifo_overflow, .irq, .dma_stall, .irq_enable_reg,
    .irq_status_reg);
  mims_host host (.clock, .reg_select, .reg_write, .reg_addr,
    .reg_wdata);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(input string what, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    host.access(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] x);
    expq.push_back(x);
    host.access(1'b0, a, 16'h0000);
  endtask
  always @(negedge clock) begin
    if (reg_rdata_valid === 1'b1) begin
      check("reg_rdata", reg_rdata, expq.pop_front());
    end
  end
  task automatic clear_ev;
    {bus_retry_input, tx_end, collision_pulse, table_load_complete,
      tx_config_read, tx_config_irq_bit, rx_sequence_written,
      tx_status_written, timer_step, timer_is_zero, tally_step,
      tally_all_ones, rx_desc_exhausted, rx_buffers_exhausted,
      rx_area_overrun, rx_fifo_overflow} = '0;
  endtask
  // one-cycle event for status bit i
  task automatic fire(input int i);
    @(posedge clock);
    #1;
    case (i)
      14: bus_retry_input = 1'b1;
      13: tx_end = 1'b1;
      12: table_load_complete = 1'b1;
      11: {tx_config_read, tx_config_irq_bit} = 2'b11;
      10: rx_sequence_written = 1'b1;
      9, 8: tx_status_written = 1'b1;
      7: {timer_step, timer_is_zero} = 2'b11;
      6: rx_desc_exhausted = 1'b1;
      5: rx_buffers_exhausted = 1'b1;
      4: rx_area_overrun = 1'b1;
      3, 2, 1: begin
        tally_step = 3'(3'h1 << (i - 1));
        tally_all_ones = tally_step;
      end
      default: rx_fifo_overflow = 1'b1;
    endcase
    @(posedge clock);
    #1;
    clear_ev();
    if (i == 13) repeat (645) @(posedge clock);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end
  initial begin
    seed = 32'had4d8540;
    err_total = 0;
    comparisons = 0;
    qual = 6'h20;
    ce = 1'b1;
    {reset, soft_reset, latched_retry_mode, bus_master} = 4'h8;
    clear_ev();
    repeat (2) @(posedge clock);
    #1 reset = 1'b0;
    rd(6'h04, 16'h0000);
    rd(6'h05, 16'h0000);
    rd(6'h00, 16'h0000);
    wr(6'h04, 16'hFFFF);
    rd(6'h04, 16'h7FFF);
    en = 16'($random(seed)) & 16'h7FFF;
    wr(6'h04, en);
    rd(6'h04, en);
    $display("test reset and enable done");
    for (int i = 0; i < 15; i++) begin
      qual = (i == 8) ? 6'h08 : 6'h20;
      e = (i == 8) ? 16'h0300 : 16'(16'h0001 << i);
      fire(i);
      check("irq_status_reg", irq_status_reg, e);
      check("irq", {15'h0, irq}, {15'h0, |(e & en)});
      wr(6'h05, 16'h0000);
      rd(6'h05, e);
      wr(6'h05, e);
      rd(6'h05, 16'h0000);
      check("irq", {15'h0, irq}, 16'h0000);
    end
    $display("test status bits done");
    for (int k = 0; k < 6; k++) begin
      qual = 6'(6'h20 >> k);
      e = (k < 2) ? 16'h0200 : 16'h0300;
      fire(9);
      rd(6'h05, e);
      wr(6'h05, e);
    end
    fork
      wr(6'h05, 16'h0400);
      fire(10);
    join
    rd(6'h05, 16'h0400);
    wr(6'h05, 16'h0400);
    fork
      fire(13);
      begin
        repeat (630) @(posedge clock);
        #1 collision_pulse = 1'b1;
        @(posedge clock);
        #1 collision_pulse = 1'b0;
      end
    join
    rd(6'h05, 16'h0000);
    $display("test transmit and heartbeat done");
    latched_retry_mode = 1'b1;
    fire(14);
    rd(6'h05, 16'h0000);
    bus_master = 1'b1;
    fire(14);
    check("dma_stall", {15'h0, dma_stall}, 16'h0001);
    wr(6'h05, 16'h4000);
    check("dma_stall", {15'h0, dma_stall}, 16'h0000);
    {latched_retry_mode, bus_master} = 2'b00;
    fire(14);
    check("dma_stall", {15'h0, dma_stall}, 16'h0000);
    rd(6'h05, 16'h4000);
    wr(6'h05, 16'h4000);
    $display("test bus retry done");
    fire(0);
    soft_reset = 1'b1;
    repeat (2) @(posedge clock);
    #1 soft_reset = 1'b0;
    rd(6'h05, 16'h0001);
    rd(6'h04, en);
    @(posedge clock);
    #1 ce = 1'b0;
    wr(6'h05, 16'h0001);
    wr(6'h04, 16'h0000);
    ce = 1'b1;
    check("irq_status_reg", irq_status_reg, 16'h0001);
    check("irq_enable_reg", irq_enable_reg, en);
    reset = 1'b1;
    @(posedge clock);
    #1 reset = 1'b0;
    rd(6'h04, 16'h0000);
    rd(6'h05, 16'h0000);
    $display("test resets done");
    report_and_stop();
  end
endmodule // tb
